// ==== hw/cpu16_pkg.sv ====
// Constants, command classes and bus carriers for the decode/timing block
package cpu16_pkg;
  localparam int unsigned CLK_PER_UC = 2;
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_OPND = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_COST = 8'h10;
  localparam logic [7:0] A_PC   = 8'h14;
  localparam logic [7:0] A_GPR  = 8'h20;
  localparam int ST_BUSY = 0;
  localparam int ST_C    = 1;
  localparam int ST_OV   = 2;
  localparam int ST_S    = 3;
  localparam int ST_Z    = 4;
  localparam int ST_IE   = 5;
  localparam int ST_DBD  = 6;
  localparam int ST_DBL  = 7;
  localparam logic [4:0] UC_DIR  = 5'h0a;
  localparam logic [4:0] UC_IND  = 5'h08;
  localparam logic [4:0] UC_STK  = 5'h0b;
  localparam logic [4:0] UC_RR   = 5'h06;
  localparam logic [4:0] UC_SH   = 5'h06;
  localparam logic [4:0] UC_SH2  = 5'h02;
  localparam logic [4:0] UC_BR   = 5'h07;
  localparam logic [4:0] UC_BRT  = 5'h02;
  localparam logic [4:0] UC_JSR  = 5'h0c;
  localparam logic [4:0] UC_DOUBLE_BYTE_PREFIX = 5'h04;
  localparam logic [4:0] UC_SIN  = 5'h06;
  localparam logic [4:0] UC_PSH  = 5'h09;
  localparam logic [4:0] UC_PUL  = 5'h0b;
  localparam logic [1:0] M_DIR = 2'h0;
  localparam logic [1:0] M_IND = 2'h1;
  localparam logic [1:0] M_STK = 2'h3;
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_CMP = 3'h2;
  localparam logic [2:0] OP_AND = 3'h3;
  localparam logic [2:0] OP_XOR = 3'h4;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [3:0] {
    CL_NOP, CL_EXT, CL_RR, CL_SHIFT, CL_BR, CL_EXTERNAL_CONDITION_BRANCH,
    CL_JSR, CL_DOUBLE_BYTE_PREFIX, CL_SIN, CL_PUSH, CL_PULL
  } class_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage

// ==== hw/cpu16_decode_timing.sv ====
// Instruction decode and microcycle timing engine with AXI4-Lite access
// Behaviour
// - Microcycle is two clocks; costs whole microcycles
// - Memory ALU ops cost 10, 8, 11
// - Register ops add one for destination 6/7
// - Two-position shift costs two more microcycles
// - Shifts act only on registers 0 to 3
// - Swap exchanges bytes; two-position swaps twice
// - Rotate left via carry, also overflow
// - Left shift via carry fills zeros
// - Arithmetic right via carry keeps sign
// - Branch adds/subtracts displacement; taken costs two more
// - Carry branches test carry set or clear
// - No-overflow and plus branches test overflow clear and sign clear
// - Minus tests sign set; zero tests zero
// - External branch picks one of sixteen inputs
// - Jump-save stores return in 4/5/6
// - Double-byte prefix marks next reference, uninterruptible
// - Push/pull are moves indirect through register 6
// - Soft interrupt only pulses its pin
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cpu16_decode_timing
  import cpu16_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire axi_req_t    axiReq,
  output axi_rsp_t         axiRsp,
  input  wire logic [15:0] extCond,
  input  wire logic        irqPin,
  output logic             softIntPin,
  output logic             intAccept,
  output logic [15:0]      memAddr,
  output logic [15:0]      memWdata,
  output logic             memWrite
);

  logic [15:0] extMeta;
  logic [15:0] extSync;
  logic        irqMeta;
  logic        irqSync;
  logic [15:0] gpr [8];
  logic [15:0] pc;
  logic [15:0] operand;
  logic        fC;
  logic        fOv;
  logic        fS;
  logic        fZ;
  logic        intEn;
  logic        dbdPending;
  logic        dblData;
  logic        busy;
  logic [5:0]  clkLeft;
  logic [4:0]  lastCost;
  logic [4:0]  cost;
  logic        taken;
  logic [31:0] rdVal;
  logic [15:0] status;
  logic        wrFire;
  logic        rdFire;
  logic        go;
  class_t      cls;
  logic [15:0] instr;
  logic [15:0] shSrc;
  logic [17:0] aluE;
  logic [17:0] aluR;
  logic [17:0] sh;
  logic [15:0] brNext;
  logic [2:0]  retSel;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a[7:5] == A_GPR[7:5] || a == A_CMD ||
             a == A_OPND || a == A_STAT || a == A_COST || a == A_PC);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Returns {carry, overflow, result}; subtract carry means no borrow
  function automatic logic [17:0] alu(input logic [2:0]  op,
                                      input logic [15:0] a,
                                      input logic [15:0] b);
    logic [15:0] bb;
    logic [16:0] s;
    bb = (op == OP_ADD) ? b : ~b;
    s = {1'b0, a} + {1'b0, bb} + {16'h0000, op != OP_ADD};
    if (op <= OP_CMP) begin
      alu = {s[16], (a[15] == bb[15]) && (s[15] != a[15]), s[15:0]};
    end else if (op == OP_AND) begin
      alu = {2'h0, a & b};
    end else if (op == OP_XOR) begin
      alu = {2'h0, a ^ b};
    end else begin
      alu = {2'h0, b};
    end
  endfunction

  // Returns {carry, overflow, result}; odd modes are two-position
  function automatic logic [17:0] shf(input logic [3:0]  m,
                                      input logic [15:0] r,
                                      input logic        c,
                                      input logic        ov);
    unique case (m)
      4'h0: shf = {c, ov, r[7:0], r[15:8]};
      4'h1: shf = {c, ov, r};
      4'h2: shf = {c, ov, r[14:0], 1'b0};
      4'h3: shf = {c, ov, r[13:0], 2'h0};
      4'h4: shf = {r[15], ov, r[14:0], c};
      4'h5: shf = {r[15], r[14], r[13:0], c, ov};
      4'h6: shf = {r[15], ov, r[14:0], 1'b0};
      4'h7: shf = {r[15], r[14], r[13:0], 2'h0};
      4'h8: shf = {c, ov, 1'b0, r[15:1]};
      4'h9: shf = {c, ov, 2'h0, r[15:2]};
      4'ha: shf = {c, ov, r[15], r[15:1]};
      4'hb: shf = {c, ov, {2{r[15]}}, r[15:2]};
      4'hc: shf = {r[0], ov, c, r[15:1]};
      4'hd: shf = {r[0], r[1], c, ov, r[15:2]};
      4'he: shf = {r[0], ov, r[15], r[15:1]};
      4'hf: shf = {r[0], r[1], {2{r[15]}}, r[15:2]};
    endcase
  endfunction

  function automatic logic condTrue(input logic [3:0] k,
                                    input logic c, input logic ov,
                                    input logic s, input logic z);
    unique case (k)
      4'h0: condTrue = 1'b1;
      4'h1: condTrue = c;
      4'h2: condTrue = !c;
      4'h3: condTrue = ov;
      4'h4: condTrue = !ov;
      4'h5: condTrue = !s;
      4'h6: condTrue = s;
      4'h7: condTrue = z;
      4'h8: condTrue = !z;
      4'h9: condTrue = s ^ ov;
      4'ha: condTrue = !(s ^ ov);
      4'hb: condTrue = z | (s ^ ov);
      4'hc: condTrue = !(z | (s ^ ov));
      4'hd: condTrue = c ^ s;
      4'he: condTrue = !(c ^ s);
      4'hf: condTrue = 1'b0;
    endcase
  endfunction

  // Pins from outside pass two flops before use
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      extMeta <= 16'h0000;
      extSync <= 16'h0000;
      irqMeta <= 1'b0;
      irqSync <= 1'b0;
    end else if (clkEn) begin
      extMeta <= extCond;
      extSync <= extMeta;
      irqMeta <= irqPin;
      irqSync <= irqMeta;
    end
  end

  assign wrFire = clkEn && axiRsp.awready && axiReq.awvalid
                  && axiReq.wvalid;
  assign rdFire = clkEn && axiRsp.arready && axiReq.arvalid;
  assign go = wrFire && axiReq.awaddr == A_CMD && !busy;
  assign cls = class_t'(axiReq.wdata[19:16]);
  assign instr = axiReq.wdata[15:0];
  assign shSrc = gpr[{1'b0, instr[1:0]}];
  assign aluE = alu(instr[5:3], gpr[instr[2:0]], operand);
  assign aluR = alu(instr[8:6], gpr[instr[2:0]], gpr[instr[5:3]]);
  assign sh = shf(instr[5:2], shSrc, fC, fOv);
  assign retSel = {1'b1, instr[1:0] == 2'h3 ? 2'h2 : instr[1:0]};

  always_comb begin
    cost = UC_SIN;
    taken = 1'b0;
    unique case (cls)
      CL_EXT: cost = instr[7:6] == M_STK ? UC_STK :
                     instr[7:6] == M_DIR ? UC_DIR : UC_IND;
      CL_RR: cost = UC_RR + {4'h0, instr[2:1] == 2'h3};
      CL_SHIFT: cost = UC_SH + (instr[2] ? UC_SH2 : 5'h00);
      CL_BR: begin
        taken = condTrue(instr[3:0], fC, fOv, fS, fZ);
        cost = UC_BR + (taken ? UC_BRT : 5'h00);
      end
      CL_EXTERNAL_CONDITION_BRANCH: begin
        taken = extSync[instr[3:0]];
        cost = UC_BR + (taken ? UC_BRT : 5'h00);
      end
      CL_JSR: cost = UC_JSR;
      CL_DOUBLE_BYTE_PREFIX: cost = UC_DOUBLE_BYTE_PREFIX;
      CL_PUSH: cost = UC_PSH;
      CL_PULL: cost = UC_PUL;
      default: cost = UC_SIN;
    endcase
  end

  // Displacement is the word after the opcode; untaken skips it
  assign brNext = !taken ? pc + 16'h0002 :
                  instr[5] ? pc + 16'h0002 - operand :
                  pc + 16'h0002 + operand;

  always_comb begin
    status = 16'h0000;
    status[ST_BUSY] = busy;
    status[ST_C] = fC;
    status[ST_OV] = fOv;
    status[ST_S] = fS;
    status[ST_Z] = fZ;
    status[ST_IE] = intEn;
    status[ST_DBD] = dbdPending;
    status[ST_DBL] = dblData;
  end

  always_comb begin
    rdVal = 32'h00000000;
    if (axiReq.araddr[7:5] == A_GPR[7:5]) begin
      rdVal = {16'h0000, gpr[axiReq.araddr[4:2]]};
    end else if (axiReq.araddr == A_OPND) begin
      rdVal = {16'h0000, operand};
    end else if (axiReq.araddr == A_STAT) begin
      rdVal = {16'h0000, status};
    end else if (axiReq.araddr == A_COST) begin
      rdVal = {27'h0000000, lastCost};
    end else if (axiReq.araddr == A_PC) begin
      rdVal = {16'h0000, pc};
    end
  end

  // Ready is raised one cycle after both write channels are valid
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      axiRsp <= '0;
    end else if (clkEn) begin
      axiRsp.awready <= !axiRsp.awready && axiReq.awvalid
                        && axiReq.wvalid && !axiRsp.bvalid;
      axiRsp.wready <= !axiRsp.awready && axiReq.awvalid
                       && axiReq.wvalid && !axiRsp.bvalid;
      axiRsp.arready <= !axiRsp.arready && axiReq.arvalid
                        && !axiRsp.rvalid;
      if (wrFire) begin
        axiRsp.bvalid <= 1'b1;
        axiRsp.bresp <= mapped(axiReq.awaddr) ? RESP_OK : RESP_ERR;
      end else if (axiReq.bready) begin
        axiRsp.bvalid <= 1'b0;
      end
      if (rdFire) begin
        axiRsp.rvalid <= 1'b1;
        axiRsp.rdata <= rdVal;
        axiRsp.rresp <= mapped(axiReq.araddr) ? RESP_OK : RESP_ERR;
      end else if (axiReq.rready) begin
        axiRsp.rvalid <= 1'b0;
      end
    end
  end

  // A command written while busy is dropped; software polls the busy bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      clkLeft <= 6'h00;
      lastCost <= 5'h00;
    end else if (clkEn) begin
      if (go) begin
        busy <= 1'b1;
        lastCost <= cost;
        clkLeft <= 6'(CLK_PER_UC * cost - 1);
      end else if (busy) begin
        if (clkLeft == 6'h00) begin
          busy <= 1'b0;
        end else begin
          clkLeft <= clkLeft - 6'h01;
        end
      end
    end
  end

  // Results land at launch; busy then only models the execution time
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= 16'h0000;
      end
      pc <= 16'h0000;
      operand <= 16'h0000;
      fC <= 1'b0;
      fOv <= 1'b0;
      fS <= 1'b0;
      fZ <= 1'b0;
      intEn <= 1'b0;
      dbdPending <= 1'b0;
      dblData <= 1'b0;
    end else if (clkEn) begin
      if (intAccept) begin
        intEn <= 1'b0;
      end
      if (wrFire) begin
        if (axiReq.awaddr[7:5] == A_GPR[7:5]) begin
          gpr[axiReq.awaddr[4:2]] <= merge(gpr[axiReq.awaddr[4:2]],
                                           axiReq.wdata, axiReq.wstrb);
        end else if (axiReq.awaddr == A_OPND) begin
          operand <= merge(operand, axiReq.wdata, axiReq.wstrb);
        end else if (axiReq.awaddr == A_PC) begin
          pc <= merge(pc, axiReq.wdata, axiReq.wstrb);
        end else if (axiReq.awaddr == A_STAT && axiReq.wstrb[0]) begin
          fC <= axiReq.wdata[ST_C];
          fOv <= axiReq.wdata[ST_OV];
          fS <= axiReq.wdata[ST_S];
          fZ <= axiReq.wdata[ST_Z];
          intEn <= axiReq.wdata[ST_IE];
        end
      end
      if (go) begin
        unique case (cls)
          CL_EXT: begin
            if (instr[5:3] != OP_CMP && instr[5:3] <= OP_XOR) begin
              gpr[instr[2:0]] <= aluE[15:0];
            end
            if (instr[5:3] <= OP_CMP) begin
              fC <= aluE[17];
              fOv <= aluE[16];
            end
            fS <= aluE[15];
            fZ <= aluE[15:0] == 16'h0000;
            dblData <= dbdPending;
            dbdPending <= 1'b0;
            pc <= pc + (instr[7:6] == M_IND ? 16'h0001 : 16'h0002);
          end
          CL_RR: begin
            if (instr[8:6] != OP_CMP) begin
              gpr[instr[2:0]] <= aluR[15:0];
            end
            if (instr[8:6] <= OP_CMP) begin
              fC <= aluR[17];
              fOv <= aluR[16];
            end
            fS <= aluR[15];
            fZ <= aluR[15:0] == 16'h0000;
            pc <= pc + 16'h0001;
          end
          CL_SHIFT: begin
            gpr[{1'b0, instr[1:0]}] <= sh[15:0];
            fC <= sh[17];
            fOv <= sh[16];
            fS <= sh[15];
            fZ <= sh[15:0] == 16'h0000;
            pc <= pc + 16'h0001;
          end
          CL_BR, CL_EXTERNAL_CONDITION_BRANCH: pc <= brNext;
          CL_JSR: begin
            gpr[retSel] <= pc + 16'h0002;
            pc <= operand;
            if (instr[3:2] == 2'h1) begin
              intEn <= 1'b1;
            end else if (instr[3:2] == 2'h2) begin
              intEn <= 1'b0;
            end
          end
          CL_DOUBLE_BYTE_PREFIX: begin
            dbdPending <= 1'b1;
            pc <= pc + 16'h0001;
          end
          CL_PUSH: begin
            gpr[6] <= gpr[6] + 16'h0001;
            dblData <= dbdPending;
            dbdPending <= 1'b0;
            pc <= pc + 16'h0001;
          end
          CL_PULL: begin
            gpr[6] <= gpr[6] - 16'h0001;
            gpr[instr[2:0]] <= operand;
            dblData <= dbdPending;
            dbdPending <= 1'b0;
            pc <= pc + 16'h0001;
          end
          default: pc <= pc + 16'h0001;
        endcase
      end
    end
  end

  // Interrupts are held off while a double-byte prefix is pending
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      softIntPin <= 1'b0;
      intAccept <= 1'b0;
      memWrite <= 1'b0;
      memAddr <= 16'h0000;
      memWdata <= 16'h0000;
    end else if (clkEn) begin
      softIntPin <= go && cls == CL_SIN;
      intAccept <= !intAccept && !busy && !go && intEn
                   && !dbdPending && irqSync;
      memWrite <= go && cls == CL_PUSH;
      if (go && cls == CL_PUSH) begin
        memAddr <= gpr[6];
        memWdata <= gpr[instr[2:0]];
      end else if (go && cls == CL_PULL) begin
        memAddr <= gpr[6] - 16'h0001;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_micro;
    busy && clkLeft == 6'h00 && clkEn |=> !busy;
  endproperty
  a_micro: assert property (p_micro)
    else $error("busy outlived its count");

  property p_span;
    go |=> busy && clkLeft == {lastCost, 1'b0} - 6'h01;
  endproperty
  a_span: assert property (p_span)
    else $error("cycle count not twice the cost");

  property p_ext;
    go && cls == CL_EXT && instr[7:6] == M_STK |=> lastCost == 5'h0b;
  endproperty
  a_ext: assert property (p_ext)
    else $error("stack operand cost wrong");

  property p_rr;
    go && cls == CL_RR && instr[2:1] == 2'h3 |=> lastCost == 5'h07;
  endproperty
  a_rr: assert property (p_rr)
    else $error("register 6/7 surcharge missing");

  property p_sh2;
    go && cls == CL_SHIFT && instr[2] |=> lastCost == 5'h08;
  endproperty
  a_sh2: assert property (p_sh2)
    else $error("two-position shift cost wrong");

  property p_shreg;
    go && cls == CL_SHIFT |=> gpr[4] == $past(gpr[4])
                              && gpr[7] == $past(gpr[7]);
  endproperty
  a_shreg: assert property (p_shreg)
    else $error("shift touched a high register");

  property p_swap;
    go && cls == CL_SHIFT && instr[5:2] == 4'h0 |=>
      gpr[{1'b0, $past(instr[1:0])}] ==
      {$past(shSrc[7:0]), $past(shSrc[15:8])};
  endproperty
  a_swap: assert property (p_swap)
    else $error("byte swap wrong");

  property p_rlc2;
    go && cls == CL_SHIFT && instr[5:2] == 4'h5 |=>
      fC == $past(shSrc[15]) && fOv == $past(shSrc[14]);
  endproperty
  a_rlc2: assert property (p_rlc2)
    else $error("rotate flags wrong");

  property p_brc;
    go && cls == CL_BR && instr[3:0] == 4'h1 && fC |=>
      lastCost == 5'h09;
  endproperty
  a_brc: assert property (p_brc)
    else $error("taken carry branch cost wrong");

  property p_nt;
    go && cls == CL_EXTERNAL_CONDITION_BRANCH && !extSync[instr[3:0]] |=>
      pc == $past(pc) + 16'h0002 && fC == $past(fC)
      && lastCost == 5'h07;
  endproperty
  a_nt: assert property (p_nt)
    else $error("untaken branch wrong");

  property p_dbd;
    dbdPending |-> !intAccept;
  endproperty
  a_dbd: assert property (p_dbd)
    else $error("interrupt taken after prefix");

  property p_push;
    go && cls == CL_PUSH |=> memWrite
      && gpr[6] == $past(gpr[6]) + 16'h0001;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not use register 6");

  property p_sin;
    go && cls == CL_SIN |=> softIntPin && !memWrite
      && gpr[0] == $past(gpr[0]);
  endproperty
  a_sin: assert property (p_sin)
    else $error("soft interrupt pulse missing");

endmodule // cpu16_decode_timing

// ==== sim/cpu16_decode_timing_tb_top.sv ====
// Self-checking bench for the decode and timing block
`timescale 1ns/1ps
module cpu16_decode_timing_tb_top
  import cpu16_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        clkEn = 1'b1;
  axi_req_t    axiReq = '0;
  axi_rsp_t    axiRsp;
  logic [15:0] extCond = 16'h0000;
  logic        irqPin = 1'b0;
  logic        softIntPin, intAccept, memWrite;
  logic [15:0] memAddr, memWdata, pushAddr, pushData;
  logic [31:0] rdData;
  logic [1:0]  rdResp, wrResp;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          nSoft = 0;
  int          nPush = 0;
  int          nAcc = 0;

  always #5 clk_sys = ~clk_sys;

  cpu16_decode_timing i_dut (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .axiReq     (axiReq),
    .axiRsp     (axiRsp),
    .extCond    (extCond),
    .irqPin     (irqPin),
    .softIntPin (softIntPin),
    .intAccept  (intAccept),
    .memAddr    (memAddr),
    .memWdata   (memWdata),
    .memWrite   (memWrite)
  );

  // Pulses last one cycle, so they are caught at every edge
  always @(posedge clk_sys) begin
    if (softIntPin === 1'b1) nSoft++;
    if (intAccept === 1'b1) nAcc++;
    if (memWrite === 1'b1) begin
      nPush++;
      pushAddr = memAddr;
      pushData = memWdata;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do @(posedge clk_sys);
    while (axiRsp.awready !== 1'b1);
    axiReq.awvalid <= 1'b0;
    axiReq.wvalid <= 1'b0;
    do @(posedge clk_sys);
    while (axiRsp.bvalid !== 1'b1);
    wrResp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axr(input logic [7:0] a);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do @(posedge clk_sys);
    while (axiRsp.arready !== 1'b1);
    axiReq.arvalid <= 1'b0;
    do @(posedge clk_sys);
    while (axiRsp.rvalid !== 1'b1);
    rdData = axiRsp.rdata;
    rdResp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(rdData, exp);
  endtask

  // A new command is only legal once the busy bit has dropped
  task automatic cmd(input logic [3:0] cl, input logic [15:0] ins);
    axw(A_CMD, {12'h000, cl, ins});
    do axr(A_STAT);
    while (rdData[ST_BUSY] !== 1'b0);
  endtask

  task automatic br(input logic [3:0] cl, input logic [15:0] ins,
                    input logic [7:0] st, input logic [15:0] pc,
                    input logic [31:0] uc);
    axw(A_STAT, {24'h0, st});
    axw(A_PC, 32'h0100);
    axw(A_OPND, 32'h0010);
    cmd(cl, ins);
    rd(A_PC, {16'h0, pc});
    rd(A_COST, uc);
  endtask

  task automatic t_reset();
    rd(A_STAT, 32'h0);
    rd(A_PC, 32'h0);
    axr(8'h1c);
    chk({30'h0, rdResp}, 32'h2);
    axw(8'h1c, 32'h1);
    chk({30'h0, wrResp}, 32'h2);
  endtask

  task automatic t_alu();
    logic [1:0] md [3] = '{M_DIR, M_IND, M_STK};
    logic [31:0] uc [3] = '{32'd10, 32'd8, 32'd11};
    axw(A_GPR + 8'h04, 32'h3);
    axw(A_OPND, 32'h5);
    for (int i = 0; i < 3; i++) begin
      cmd(4'h1, {8'h00, md[i], OP_ADD, 3'd1});
      rd(A_COST, uc[i]);
      rd(A_GPR + 8'h04, 32'h8 + 32'h5 * i);
    end
    cmd(4'h1, {8'h00, M_IND, OP_XOR, 3'd1});
    rd(A_GPR + 8'h04, 32'h17);
    cmd(4'h2, 16'h014a);
    rd(A_COST, 32'd6);
    rd(A_GPR + 8'h08, 32'h17);
    cmd(4'h2, 16'h014e);
    rd(A_COST, 32'd7);
  endtask

  task automatic t_shift();
    axw(A_GPR, 32'h1234);
    cmd(4'h3, 16'h0000);
    rd(A_GPR, 32'h3412);
    rd(A_COST, 32'd6);
    cmd(4'h3, 16'h0004);
    rd(A_GPR, 32'h3412);
    rd(A_COST, 32'd8);
    axw(A_GPR + 8'h0c, 32'h8001);
    axw(A_STAT, 32'h0);
    cmd(4'h3, 16'h001b);
    rd(A_GPR + 8'h0c, 32'h0002);
    rd(A_STAT, 32'h2);
    cmd(4'h3, 16'h0013);
    rd(A_GPR + 8'h0c, 32'h0005);
    axw(A_GPR + 8'h0c, 32'hc005);
    cmd(4'h3, 16'h0017);
    rd(A_GPR + 8'h0c, 32'h0014);
    rd(A_STAT, 32'h6);
    axw(A_GPR + 8'h0c, 32'h8001);
    cmd(4'h3, 16'h003b);
    rd(A_GPR + 8'h0c, 32'hc000);
    axr(A_STAT);
    chk({31'h0, rdData[ST_C]}, 32'h1);
  endtask

  task automatic t_branch();
    br(4'h4, 16'h0001, 8'h02, 16'h0112, 32'd9);
    br(4'h4, 16'h0001, 8'h00, 16'h0102, 32'd7);
    br(4'h4, 16'h0002, 8'h00, 16'h0112, 32'd9);
    br(4'h4, 16'h0021, 8'h02, 16'h00f2, 32'd9);
    br(4'h4, 16'h0004, 8'h04, 16'h0102, 32'd7);
    br(4'h4, 16'h0005, 8'h00, 16'h0112, 32'd9);
    br(4'h4, 16'h0005, 8'h08, 16'h0102, 32'd7);
    br(4'h4, 16'h0006, 8'h08, 16'h0112, 32'd9);
    br(4'h4, 16'h0007, 8'h10, 16'h0112, 32'd9);
    br(4'h4, 16'h0007, 8'h00, 16'h0102, 32'd7);
    rd(A_STAT, 32'h0);
    for (int i = 0; i < 16; i++) begin
      extCond <= 16'h0001 << i;
      br(4'h5, 16'(i), 8'h0, 16'h0112, 32'd9);
      br(4'h5, 16'((i + 1) % 16), 8'h0, 16'h0102, 32'd7);
    end
  endtask

  task automatic t_misc();
    int n0;
    axw(A_PC, 32'h0200);
    axw(A_OPND, 32'h0300);
    cmd(4'h6, 16'h0000);
    rd(A_GPR + 8'h10, 32'h0202);
    rd(A_PC, 32'h0300);
    cmd(4'h6, 16'h0005);
    rd(A_GPR + 8'h14, 32'h0302);
    rd(A_STAT, 32'h20);
    cmd(4'h6, 16'h000a);
    rd(A_GPR + 8'h18, 32'h0302);
    rd(A_STAT, 32'h0);
    axw(A_GPR + 8'h18, 32'h0040);
    axw(A_GPR + 8'h08, 32'habcd);
    n0 = nPush;
    cmd(4'h9, 16'h0002);
    chk(32'(nPush - n0), 32'h1);
    chk({pushAddr, pushData}, 32'h0040abcd);
    rd(A_GPR + 8'h18, 32'h41);
    axw(A_OPND, 32'h5555);
    cmd(4'ha, 16'h0003);
    chk({16'h0, memAddr}, 32'h0040);
    rd(A_GPR + 8'h18, 32'h40);
    rd(A_GPR + 8'h0c, 32'h5555);
    n0 = nSoft;
    cmd(4'h8, 16'h0000);
    chk(32'(nSoft - n0), 32'h1);
    rd(A_GPR, 32'h3412);
    cmd(4'h7, 16'h0000);
    axr(A_STAT);
    chk({31'h0, rdData[ST_DBD]}, 32'h1);
    // Request held off until the prefixed reference has run
    n0 = nAcc;
    axw(A_STAT, 32'h20);
    irqPin <= 1'b1;
    rd(A_STAT, 32'h60);
    rd(A_STAT, 32'h60);
    chk(32'(nAcc - n0), 32'h0);
    cmd(4'h1, {8'h00, M_IND, OP_AND, 3'd0});
    rd(A_STAT, 32'h80);
    chk(32'(nAcc - n0), 32'h1);
    rd(A_GPR, 32'h1410);
    irqPin <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_alu();
    t_shift();
    t_branch();
    t_misc();
    complete_run();
  end

  // Whole run needs some 2500 cycles; this leaves a wide margin
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end
endmodule // cpu16_decode_timing_tb_top
